// ---- cpmc_pkg.sv ----
/*
  Package for the CPU power mode control block: register offsets, field
  positions, reset values and throttle ratio constants.
  Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
*/
`default_nettype none

package cpmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CPMC_REGULATOR_OFS = 4'h0;  // regulator_sleep_control
  localparam logic [3:0] CPMC_THROTTLE_OFS  = 4'h4;  // cpu_throttle_idle_control
  localparam logic [3:0] CPMC_STATUS_OFS    = 4'h8;  // Block state, read only

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CPMC_REG_RSVD_BIT  = 0;
  localparam int CPMC_REG_LP_BIT    = 1;
  localparam int CPMC_THR_IDLE_BIT  = 7;
  localparam int CPMC_THR_ACT_BIT   = 6;
  localparam int CPMC_THR_ROI_BIT   = 5;
  localparam int CPMC_THR_RET_BIT   = 4;
  localparam int CPMC_RATIO_MSB     = 2;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CPMC_REGULATOR_RST = 8'h01;
  localparam logic [7:0] CPMC_REGULATOR_WM  = 8'h02;
  localparam logic [7:0] CPMC_THROTTLE_RST  = 8'h00;
  localparam logic [7:0] CPMC_THROTTLE_WM   = 8'hf7;

  // ----------------------------------------------------------------
  // Throttle counter
  // ----------------------------------------------------------------
  localparam int         CPMC_CNT_W   = 8;
  localparam logic [7:0] CPMC_CNT_RST = 8'h00;

endpackage

`default_nettype wire

// ---- cpmc_throttle.sv ----
/*
  Throttle divider: a free-running count of peripheral instruction cycles
  that grants one CPU cycle each time it wraps at the selected ratio.
  Assumes a peripheral cycle strobe from the core clock generator.
*/
`default_nettype none

module cpmc_throttle #(
  parameter int CNT_W = cpmc_pkg::CPMC_CNT_W
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Control
  input  wire logic             periph_cycle,
  input  wire logic [2:0]       ratio,
  // Result
  output logic                  wrap_pulse
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] wrap_mask;

  // Ratio 000 is 1:2, so the mask holds ratio+1 low ones
  assign wrap_mask  = CNT_W'((9'h002 << ratio) - 9'h001);
  assign cnt_next   = periph_cycle ? cnt_reg + 1'b1 : cnt_reg;
  assign wrap_pulse = periph_cycle && ((cnt_reg & wrap_mask) == wrap_mask);

  // Counter never stops, peripherals are never gated
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg <= CNT_W'(cpmc_pkg::CPMC_CNT_RST);
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

// ---- cpmc_avalon.sv ----
/*
  Avalon-MM slave front end: one wait state on each access, word
  decode and byte-lane strobes for the low byte.
  Assumes a master that holds its request until waitrequest is low.
*/
`default_nettype none

module cpmc_avalon (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Avalon-MM
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  output logic             avs_waitrequest,
  // Register side
  output logic             wr_fire,
  output logic             rd_fire,
  output logic [1:0]       word_sel,
  output logic             lane0
);

  logic pend_reg;

  // One wait state: answer on the second edge of a request
  assign avs_waitrequest = (avs_read || avs_write) && !pend_reg;
  assign wr_fire  = avs_write && pend_reg;
  assign rd_fire  = avs_read && !pend_reg;  // Capture in the wait cycle
  assign word_sel = avs_address[3:2];
  assign lane0    = avs_byteenable[0];

  // Pending flag drops on the edge that completes the access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= (avs_read || avs_write) && !pend_reg;
    end
  end

endmodule

`default_nettype wire

// ---- cpmc_top.sv ----
/*
  CPU power mode control: regulator sleep state, idle on sleep and CPU
  throttling with interrupt recovery and re-throttle on return.
  Assumes core strobes are one-cycle pulses on sys_clk and that the
  power-on/brown-out reset is a synchronous level on sys_clk.
*/
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`default_nettype none

module cpmc_top (
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        power_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // CPU core sequencing
  input  wire logic        periph_cycle,
  input  wire logic        sleep_instr,
  input  wire logic        irq_entry,
  input  wire logic        irq_return,
  input  wire logic        irq_pending,
  input  wire logic        watchdog_timeout,
  input  wire logic        in_circuit_debug,
  // Power outputs
  output logic             cpu_cycle_en,
  output logic             cpu_clk_stop,
  output logic             full_sleep,
  output logic             regulator_lowpower,
  output logic             watchdog_wake,
  output logic             watchdog_reset
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPMC_RUN   = 2'b00,
    CPMC_IDLE  = 2'b01,
    CPMC_SLEEP = 2'b10
  } cpmc_state_t;

  cpmc_state_t state_reg;
  cpmc_state_t state_next;
  logic        lp_reg;
  logic        idle_sel_reg;
  logic        act_reg;
  logic        act_next;
  logic        roi_reg;
  logic        ret_reg;
  logic [2:0]  ratio_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic [1:0]  word_sel;
  logic        lane0;
  logic        wr_reg_sel;
  logic        wr_thr_sel;
  logic        hw_clear;
  logic        hw_set;
  logic        wrap_pulse;
  logic        idle_wake;
  logic [7:0]  reg_rd;
  logic [7:0]  thr_rd;
  logic [7:0]  sta_rd;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Bus front end and divider
  // ----------------------------------------------------------------
  cpmc_avalon u_bus (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_waitrequest (avs_waitrequest),
    .wr_fire         (wr_fire),
    .rd_fire         (rd_fire),
    .word_sel        (word_sel),
    .lane0           (lane0)
  );

  cpmc_throttle u_thr (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .periph_cycle (periph_cycle),
    .ratio        (ratio_reg),
    .wrap_pulse   (wrap_pulse)
  );

  // ----------------------------------------------------------------
  // Write decode and hardware updates
  // ----------------------------------------------------------------
  assign wr_reg_sel = wr_fire && lane0 && (word_sel == cpmc_pkg::CPMC_REGULATOR_OFS[3:2]);
  assign wr_thr_sel = wr_fire && lane0 && (word_sel == cpmc_pkg::CPMC_THROTTLE_OFS[3:2]);
  assign hw_clear   = irq_entry && roi_reg;
  assign hw_set     = irq_return && ret_reg;
  // Software write first, then interrupt entry/return overrides it
  assign act_next   = hw_clear ? 1'b0 :
                      hw_set   ? 1'b1 :
                      wr_thr_sel ? avs_writedata[cpmc_pkg::CPMC_THR_ACT_BIT] : act_reg;

  // Regulator register: only bit 1 is storage, cleared by every reset
  always_ff @(posedge sys_clk) begin
    if (srst || power_rst) begin
      lp_reg <= cpmc_pkg::CPMC_REGULATOR_RST[cpmc_pkg::CPMC_REG_LP_BIT];
    end else if (wr_reg_sel) begin
      lp_reg <= avs_writedata[cpmc_pkg::CPMC_REG_LP_BIT];
    end
  end

  // Idle select survives every reset but power-on/brown-out
  always_ff @(posedge sys_clk) begin
    if (power_rst) begin
      idle_sel_reg <= cpmc_pkg::CPMC_THROTTLE_RST[cpmc_pkg::CPMC_THR_IDLE_BIT];
    end else if (wr_thr_sel) begin
      idle_sel_reg <= avs_writedata[cpmc_pkg::CPMC_THR_IDLE_BIT];
    end
  end

  // Throttle fields; bit 3 has no storage
  always_ff @(posedge sys_clk) begin
    if (srst || power_rst) begin
      act_reg   <= cpmc_pkg::CPMC_THROTTLE_RST[cpmc_pkg::CPMC_THR_ACT_BIT];
      roi_reg   <= cpmc_pkg::CPMC_THROTTLE_RST[cpmc_pkg::CPMC_THR_ROI_BIT];
      ret_reg   <= cpmc_pkg::CPMC_THROTTLE_RST[cpmc_pkg::CPMC_THR_RET_BIT];
      ratio_reg <= cpmc_pkg::CPMC_THROTTLE_RST[cpmc_pkg::CPMC_RATIO_MSB:0];
    end else begin
      act_reg <= act_next;
      if (wr_thr_sel) begin
        roi_reg   <= avs_writedata[cpmc_pkg::CPMC_THR_ROI_BIT];
        ret_reg   <= avs_writedata[cpmc_pkg::CPMC_THR_RET_BIT];
        ratio_reg <= avs_writedata[cpmc_pkg::CPMC_RATIO_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep and idle sequencing
  // ----------------------------------------------------------------
  assign idle_wake = irq_pending || watchdog_timeout;

  // Next power state
  always_comb begin
    case (state_reg)
      CPMC_RUN: begin
        if (sleep_instr && idle_sel_reg) begin
          state_next = CPMC_IDLE;
        end else if (sleep_instr) begin
          state_next = CPMC_SLEEP;
        end else begin
          state_next = CPMC_RUN;
        end
      end
      CPMC_IDLE:  state_next = idle_wake ? CPMC_RUN : CPMC_IDLE;
      CPMC_SLEEP: state_next = idle_wake ? CPMC_RUN : CPMC_SLEEP;
      default:    state_next = CPMC_RUN;
    endcase
  end

  // Power state register
  always_ff @(posedge sys_clk) begin
    if (srst || power_rst) begin
      state_reg <= CPMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  assign cpu_clk_stop       = (state_reg == CPMC_IDLE);
  assign full_sleep         = (state_reg == CPMC_SLEEP);
  assign regulator_lowpower = lp_reg;
  // Watchdog wakes from idle or sleep, resets only while running
  assign watchdog_wake      = watchdog_timeout && (state_reg != CPMC_RUN);
  assign watchdog_reset     = watchdog_timeout && (state_reg == CPMC_RUN);
  // Recovery uses the updated bit combinationally for immediate effect
  assign cpu_cycle_en = (state_reg == CPMC_RUN) &&
                        (in_circuit_debug || !act_reg || hw_clear ||
                         wrap_pulse);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign reg_rd = {6'h00, lp_reg, 1'b1};
  assign thr_rd = {idle_sel_reg, act_reg, roi_reg, ret_reg, 1'b0, ratio_reg};
  assign sta_rd = {5'h00, in_circuit_debug, state_reg};
  assign rd_mux = (word_sel == cpmc_pkg::CPMC_REGULATOR_OFS[3:2]) ? {24'h000000, reg_rd} :
                  (word_sel == cpmc_pkg::CPMC_THROTTLE_OFS[3:2])  ? {24'h000000, thr_rd} :
                  (word_sel == cpmc_pkg::CPMC_STATUS_OFS[3:2])    ? {24'h000000, sta_rd} :
                  32'h00000000;

  // Read data loaded in the wait cycle, so it stands when waitrequest drops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_fire) begin
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  roi_clears_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    irq_entry && roi_reg |=> !act_reg)
    else $error("throttle not cleared on interrupt entry");
  roi_keeps_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    irq_entry && !roi_reg && !irq_return && !wr_thr_sel |=> act_reg == $past(act_reg))
    else $error("throttle changed on entry without recovery");
  ret_sets_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    irq_return && ret_reg && !irq_entry |=> act_reg)
    else $error("throttle not set on return");
  hw_only_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    !wr_thr_sel && !(irq_entry && roi_reg) && !(irq_return && ret_reg)
    |=> $stable(act_reg))
    else $error("throttle changed without cause");
  idle_enter_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    state_reg == CPMC_RUN && sleep_instr && idle_sel_reg |=> cpu_clk_stop && !full_sleep)
    else $error("sleep with idle select did not idle");
  sleep_enter_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    state_reg == CPMC_RUN && sleep_instr && !idle_sel_reg |=> full_sleep)
    else $error("sleep without idle select did not sleep");
  idle_exit_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    cpu_clk_stop && idle_wake && !wr_thr_sel |=> !cpu_clk_stop && $stable(idle_sel_reg))
    else $error("idle exit wrong");
  wdt_wake_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    cpu_clk_stop && watchdog_timeout |-> watchdog_wake && !watchdog_reset)
    else $error("watchdog reset in idle");
  debug_full_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    in_circuit_debug && state_reg == CPMC_RUN |-> cpu_cycle_en)
    else $error("debug not at full speed");
  full_speed_a: assert property (@(posedge sys_clk) disable iff (srst || power_rst)
    !act_reg && state_reg == CPMC_RUN |-> cpu_cycle_en)
    else $error("unthrottled cycle suppressed");
  reserved_one_a: assert property (@(posedge sys_clk) disable iff (srst)
    rd_fire && word_sel == 2'b00 |=> avs_readdata == {24'h000000, 6'h00, lp_reg, 1'b1})
    else $error("regulator read wrong");

  idle_cov: cover property (@(posedge sys_clk) cpu_clk_stop ##1 !cpu_clk_stop);
  sleep_cov: cover property (@(posedge sys_clk) full_sleep ##1 !full_sleep);
  recover_cov: cover property (@(posedge sys_clk) act_reg && irq_entry && roi_reg);
  rethrottle_cov: cover property (@(posedge sys_clk) irq_return && ret_reg ##1 act_reg);

endmodule

`default_nettype wire

// ---- cpmc_core_model.sv ----
/*
  CPU core model: peripheral cycle strobe and one-clock core strobes for
  sleep, interrupt entry, interrupt return, wake request and watchdog.
  Assumes the bench calls strobe() and the block samples on sys_clk.
*/
`default_nettype none

module cpmc_core_model (
  // Clock
  input  wire logic sys_clk,
  // Block outputs seen by the core
  input  wire logic cpu_cycle_en,
  input  wire logic watchdog_wake,
  input  wire logic watchdog_reset,
  // Core strobes
  output logic      periph_cycle,
  output logic      sleep_instr,
  output logic      irq_entry,
  output logic      irq_return,
  output logic      irq_pending,
  output logic      watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;

  logic slow;  // Peripheral cycle only every other clock

  // -------------------------------------------------------------
  // Idle levels at time zero
  // -------------------------------------------------------------
  initial begin
    slow = 1'b0;
    periph_cycle = 1'b1;
    {sleep_instr, irq_entry, irq_return, irq_pending, watchdog_timeout} = 5'h00;
  end

  // Peripheral cycle strobe, prompt or slow
  always @(posedge sys_clk) begin
    periph_cycle <= slow ? ~periph_cycle : 1'b1;
  end

  // One strobe for one clock: 0 sleep, 1 entry, 2 return, 3 wake, 4 timeout
  task automatic strobe(input int k, output logic [2:0] seen);
    @(posedge sys_clk);
    {sleep_instr, irq_entry, irq_return, irq_pending, watchdog_timeout} <= 5'(5'h10 >> k);
    @(posedge sys_clk);
    seen = {cpu_cycle_en, watchdog_wake, watchdog_reset};
    {sleep_instr, irq_entry, irq_return, irq_pending, watchdog_timeout} <= 5'h00;
  endtask

endmodule

`default_nettype wire

// ---- tb_cpu_power_mode_control.sv ----
/*
  Self-checking bench for the CPU power mode control block.
  Assumes the block keeps waitrequest high until it can answer.
*/
`default_nettype none

module tb_cpu_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, srst, power_rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        periph_cycle, sleep_instr, irq_entry, irq_return, irq_pending;
  logic        watchdog_timeout, in_circuit_debug, cpu_cycle_en, cpu_clk_stop;
  logic        full_sleep, regulator_lowpower, watchdog_wake, watchdog_reset;
  logic [2:0]  s;
  int          failures, checked, cyc, c;

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

  // -------------------------------------------------------------
  // Design and core model
  // -------------------------------------------------------------
  cpmc_top i_dut (.sys_clk(sys_clk), .srst(srst), .power_rst(power_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_cycle(periph_cycle), .sleep_instr(sleep_instr), .irq_entry(irq_entry),
    .irq_return(irq_return), .irq_pending(irq_pending),
    .watchdog_timeout(watchdog_timeout), .in_circuit_debug(in_circuit_debug),
    .cpu_cycle_en(cpu_cycle_en), .cpu_clk_stop(cpu_clk_stop), .full_sleep(full_sleep),
    .regulator_lowpower(regulator_lowpower), .watchdog_wake(watchdog_wake),
    .watchdog_reset(watchdog_reset));

  cpmc_core_model i_core (.sys_clk(sys_clk), .cpu_cycle_en(cpu_cycle_en),
    .watchdog_wake(watchdog_wake), .watchdog_reset(watchdog_reset),
    .periph_cycle(periph_cycle), .sleep_instr(sleep_instr), .irq_entry(irq_entry),
    .irq_return(irq_return), .irq_pending(irq_pending),
    .watchdog_timeout(watchdog_timeout));

  // -------------------------------------------------------------
  // Clock, timeout and verdict
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Cut a hang short well beyond the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Avalon-MM master: hold until waitrequest low, data taken at that edge
  // -------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, q)
  endtask

  // Count CPU cycle grants over 512 clocks
  task automatic cnt(output int n);
    n = 0;
    repeat (512) begin
      @(negedge sys_clk);
      n += (cpu_cycle_en === 1'b1) ? 1 : 0;
    end
  endtask

  // Pulse one reset: 1 power reset, 0 ordinary reset
  task automatic rst(input logic p);
    @(posedge sys_clk);
    if (p) power_rst <= 1'b1;
    else srst <= 1'b1;
    @(posedge sys_clk);
    {srst, power_rst} <= 2'b00;
    @(negedge sys_clk);
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {srst, power_rst} = 2'b11;
    {avs_read, avs_write, in_circuit_debug} = 3'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h00000000;
    repeat (8) @(posedge sys_clk);
    {srst, power_rst} <= 2'b00;
    rd(4'h0, 32'h01, "regulator reset");
    rd(4'h4, 32'h00, "throttle reset");
    rd(4'hc, 32'h00, "unmapped read");
    wr(4'h0, 8'hff);
    rd(4'h0, 32'h03, "regulator all ones");
    `CHK("lowpower set", 1'b1, regulator_lowpower)
    wr(4'h0, 8'h01);
    rd(4'h0, 32'h01, "regulator normal");
    `CHK("lowpower clear", 1'b0, regulator_lowpower)
    wr(4'h4, 8'hff);
    rd(4'h4, 32'hf7, "throttle all ones");
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      @(posedge sys_clk);
      i_core.slow <= r[0];
      wr(4'h4, 8'h40 | 8'(r));
      cnt(c);
      `CHK("ratio grants", (r[0] ? 256 : 512) >> (r + 1), c)
    end
    @(posedge sys_clk);
    i_core.slow <= 1'b0;
    wr(4'h4, 8'h07);
    cnt(c);
    `CHK("full speed grants", 512, c)
    wr(4'h4, 8'h47);
    in_circuit_debug <= 1'b1;
    cnt(c);
    `CHK("debug grants", 512, c)
    rd(4'h4, 32'h47, "debug keeps active");
    rd(4'h8, 32'h04, "status in debug");
    in_circuit_debug <= 1'b0;
    $display("test throttle done");
    wr(4'h4, 8'h67);
    i_core.strobe(1, s);
    `CHK("grant at entry", 1'b1, s[2])
    rd(4'h4, 32'h27, "entry recovers");
    wr(4'h4, 8'h47);
    i_core.strobe(1, s);
    rd(4'h4, 32'h47, "entry keeps");
    wr(4'h4, 8'h17);
    i_core.strobe(2, s);
    rd(4'h4, 32'h57, "return throttles");
    wr(4'h4, 8'h07);
    i_core.strobe(2, s);
    rd(4'h4, 32'h07, "return keeps");
    $display("test interrupts done");
    wr(4'h4, 8'hc7);
    i_core.strobe(0, s);
    @(negedge sys_clk);
    `CHK("idle entered", 2'b10, {cpu_clk_stop, full_sleep})
    i_core.strobe(3, s);
    @(negedge sys_clk);
    `CHK("idle ended", 1'b0, cpu_clk_stop)
    rd(4'h4, 32'hc7, "idle select kept");
    i_core.strobe(0, s);
    @(negedge sys_clk);
    `CHK("idle again", 1'b1, cpu_clk_stop)
    i_core.strobe(4, s);
    `CHK("watchdog wakes", 2'b10, s[1:0])
    @(negedge sys_clk);
    `CHK("watchdog ends idle", 1'b0, cpu_clk_stop)
    rd(4'h4, 32'hc7, "watchdog keeps active");
    i_core.strobe(4, s);
    `CHK("watchdog resets", 2'b01, s[1:0])
    wr(4'h4, 8'h00);
    i_core.strobe(0, s);
    @(negedge sys_clk);
    `CHK("full sleep", 2'b01, {cpu_clk_stop, full_sleep})
    i_core.strobe(4, s);
    @(negedge sys_clk);
    `CHK("sleep woken", 1'b0, full_sleep)
    $display("test sleep done");
    wr(4'h4, 8'hd7);
    wr(4'h0, 8'h03);
    rst(1'b0);
    rd(4'h4, 32'h80, "ordinary reset");
    rd(4'h0, 32'h01, "regulator after reset");
    wr(4'h0, 8'h03);
    rst(1'b1);
    rd(4'h4, 32'h00, "power reset");
    rd(4'h0, 32'h01, "regulator power reset");
    $display("test resets done");
    results();
  end

endmodule

`default_nettype wire
